// file: hdl/pwr_ctl_pkg.sv
// Purpose: Shared constants for the reset and low-power controller.
// Assumes: 100 MHz aclk stands in for the oscillator input.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
package pwr_ctl_pkg;
    localparam int OSC_PER_MC = 12;
    localparam int RST_HOLD_MC = 2;
    localparam logic [3:0] MC_CNT_W1 = 4'h0;
    localparam logic [11:0] OFF_PWR_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_WAKE = 12'h008;
    localparam int BIT_IDLE = 0;
    localparam int BIT_PDOWN = 1;
    localparam logic [7:0] PWR_CTRL_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_IDLE = 3'b010,
        ST_PDOWN = 3'b100
    } pmode_t;
endpackage

// file: hdl/reset_filter.sv
// Purpose: Counts reset-pin high time in machine cycles.
// Assumes: pin_sync is already synchronised; mc_tick is a one-cycle enable.
// Notes: Internal reset rises after the pin is seen high on hold_mc ticks.
`timescale 1ns/1ps
module reset_filter
    import pwr_ctl_pkg::*;
#(
    parameter int HOLD_MC = RST_HOLD_MC
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin and timing
    input wire logic pin_sync,
    input wire logic mc_tick,
    // Result
    output logic rst_active
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_rst_active;

    always_comb
    begin
        next_cnt = cnt;
        next_rst_active = rst_active;
        if (!pin_sync)
        begin
            next_cnt = '0;
            next_rst_active = 1'b0;
        end
        else if (mc_tick)
        begin
            if (cnt >= 4'(HOLD_MC - 1))
                next_rst_active = 1'b1;
            else
                next_cnt = cnt + 4'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= '0;
            rst_active <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            rst_active <= next_rst_active;
        end
    end
endmodule // reset_filter

// file: hdl/pwr_ctl.sv
// Purpose: Reset capture, clock entry and idle/power-down control.
// Assumes: aclk is the oscillator input; core handshakes are on aclk.
// Notes: Pins reset_pin and ext_code_sel_pin are asynchronous.
// How it works
// RULE1: Reset needs pin high two machine cycles.
// RULE2: Outside holds reset through oscillator start-up.
// RULE3: Code select latched only during reset.
// RULE4: Clock entry divided by two first.
// RULE5: Security option blocks internal code reads made from external code or in test mode.
// RULE6: Only table reads return program bytes.
// RULE7: Idle halts core, peripherals stay clocked.
// RULE8: Idle keeps core, RAM, registers intact.
// RULE9: Enabled interrupt leaves idle to handler.
// RULE10: Reset in idle restarts like power-on.
// RULE11: Power-down stops the oscillator.
// RULE12: Power-down keeps only RAM contents.
// RULE13: Only reset leaves power-down.
// RULE14: Mode request bits live in power control.
// RULE15: Idle drives both strobes high.
// RULE16: Power-down drives both strobes low.
// RULE17: Both requests set gives power-down; clear on exit.
// RULE18: Machine cycle is twelve oscillator periods.
`timescale 1ns/1ps
module pwr_ctl
    import pwr_ctl_pkg::*;
#(
    parameter bit SECURE = 1'b0
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic reset_pin,
    input wire logic ext_code_sel_pin,
    // Core side
    input wire logic irq_pending,
    input wire logic code_read_req,
    input wire logic code_read_is_table,
    input wire logic code_read_internal,
    input wire logic fetch_from_external,
    input wire logic test_mode_read,
    // Outputs
    output logic core_reset,
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic osc_run,
    output logic ram_only_retain,
    output logic ext_code_select,
    output logic code_read_grant,
    output logic ale_force,
    output logic ale_force_val,
    output logic code_fetch_strobe_force,
    output logic code_fetch_strobe_val,
    output logic port0_float,
    output logic port2_addr
);
    // ==========================================================
    // Pin synchronisers and clock division
    logic rst_s1, rst_s2, eas1, eas2;
    logic div2, next_div2;
    logic [3:0] mc_cnt, next_mc_cnt;
    logic mc_tick;
    logic rst_active;

    always_ff @(posedge aclk)
    begin
        rst_s1 <= reset_pin;
        rst_s2 <= rst_s1;
        eas1 <= ext_code_sel_pin;
        eas2 <= eas1;
    end

    always_comb
    begin
        next_div2 = ~div2; // [RULE4]
        next_mc_cnt = mc_cnt;
        if (div2)
            next_mc_cnt = (mc_cnt == 4'(OSC_PER_MC / 2 - 1)) ? MC_CNT_W1 : mc_cnt + 4'h1; // [RULE18]
    end
    assign mc_tick = div2 && (mc_cnt == 4'(OSC_PER_MC / 2 - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div2 <= 1'b0;
            mc_cnt <= MC_CNT_W1;
        end
        else
        begin
            div2 <= next_div2;
            mc_cnt <= next_mc_cnt;
        end
    end

    reset_filter #(.HOLD_MC(RST_HOLD_MC)) u_rf
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_sync(rst_s2),
        .mc_tick(mc_tick),
        .rst_active(rst_active) // [RULE1] [RULE2]
    );

    // ==========================================================
    // Power mode state
    pmode_t mode, next_mode;
    logic [7:0] pwr_ctrl, next_pwr_ctrl;
    logic ea_lat, next_ea_lat;
    logic wr_fire, rd_fire;
    logic [11:0] wa;
    logic [31:0] wd;
    logic woke_irq, next_woke_irq;

    always_comb
    begin
        next_mode = mode;
        next_pwr_ctrl = pwr_ctrl;
        next_ea_lat = ea_lat;
        next_woke_irq = woke_irq;
        if (rst_active)
        begin
            next_mode = ST_RUN; // [RULE10] [RULE13]
            next_pwr_ctrl = PWR_CTRL_RST;
            next_ea_lat = eas2; // [RULE3]
            next_woke_irq = 1'b0;
        end
        else
        begin
            if (wr_fire && wa == OFF_PWR_CTRL && s_axi_wstrb[0])
                next_pwr_ctrl = wd[7:0]; // [RULE14]
            if (wr_fire && wa == OFF_WAKE && s_axi_wstrb[0] && wd[0])
                next_woke_irq = 1'b0;
            case (mode)
                ST_RUN:
                begin
                    if (pwr_ctrl[BIT_PDOWN])
                        next_mode = ST_PDOWN; // [RULE17] [RULE11]
                    else if (pwr_ctrl[BIT_IDLE])
                        next_mode = ST_IDLE; // [RULE7]
                end
                ST_IDLE:
                begin
                    if (irq_pending)
                    begin
                        next_mode = ST_RUN; // [RULE9]
                        next_pwr_ctrl[BIT_IDLE] = 1'b0; // [RULE17]
                        next_woke_irq = 1'b1;
                    end
                end
                ST_PDOWN: next_mode = ST_PDOWN; // [RULE13]
                default: next_mode = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode <= ST_RUN;
            pwr_ctrl <= PWR_CTRL_RST;
            ea_lat <= 1'b0;
            woke_irq <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            pwr_ctrl <= next_pwr_ctrl;
            ea_lat <= next_ea_lat;
            woke_irq <= next_woke_irq;
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_reset <= 1'b1;
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            osc_run <= 1'b1;
            ram_only_retain <= 1'b0;
            ext_code_select <= 1'b0;
            code_read_grant <= 1'b0;
            ale_force <= 1'b0;
            ale_force_val <= 1'b0;
            code_fetch_strobe_force <= 1'b0;
            code_fetch_strobe_val <= 1'b0;
            port0_float <= 1'b0;
            port2_addr <= 1'b0;
        end
        else
        begin
            core_reset <= rst_active; // [RULE10]
            core_clk_en <= div2 && next_mode == ST_RUN && !rst_active; // [RULE7] [RULE8]
            periph_clk_en <= div2 && next_mode != ST_PDOWN; // [RULE7]
            osc_run <= next_mode != ST_PDOWN; // [RULE11]
            ram_only_retain <= next_mode == ST_PDOWN; // [RULE12]
            ext_code_select <= next_ea_lat;
            code_read_grant <= code_read_req && code_read_is_table && !(SECURE && code_read_internal
                && (fetch_from_external || test_mode_read)); // [RULE5] [RULE6]
            ale_force <= next_mode != ST_RUN;
            ale_force_val <= next_mode == ST_IDLE; // [RULE15] [RULE16]
            code_fetch_strobe_force <= next_mode != ST_RUN;
            code_fetch_strobe_val <= next_mode == ST_IDLE; // [RULE15] [RULE16]
            port0_float <= next_mode != ST_RUN && next_ea_lat;
            port2_addr <= next_mode == ST_IDLE && next_ea_lat; // [RULE15]
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_h, w_h, next_aw_h, next_w_h, next_bvalid, next_rvalid;
    logic [11:0] awa, next_awa;
    logic [31:0] wdat, next_wdat, next_rdata;
    logic [1:0] next_bresp, next_rresp;
    assign wr_fire = aw_h && w_h && !s_axi_bvalid;
    assign wa = awa;
    assign wd = wdat;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        next_aw_h = aw_h;
        next_w_h = w_h;
        next_awa = awa;
        next_wdat = wdat;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_h = 1'b1;
            next_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_h = 1'b1;
            next_wdat = s_axi_wdata;
        end
        if (wr_fire)
        begin
            next_aw_h = 1'b0;
            next_w_h = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (awa == OFF_PWR_CTRL || awa == OFF_WAKE) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (rd_fire)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFF_PWR_CTRL: next_rdata = {24'h0000_00, pwr_ctrl};
                OFF_STATUS: next_rdata = {28'h000_0000, ea_lat, mode};
                OFF_WAKE: next_rdata = {31'h0, woke_irq};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            awa <= '0;
            wdat <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end
        else
        begin
            aw_h <= next_aw_h;
            w_h <= next_w_h;
            awa <= next_awa;
            wdat <= next_wdat;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_awready <= !next_aw_h && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !next_w_h && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= !next_rvalid && !rd_fire;
        end
    end

    // ==========================================================
    // Checks
    mode_pd_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == ST_PDOWN && !rst_active) |=> mode == ST_PDOWN) else $error("power-down left without reset"); // [RULE13]
    pd_strobes_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == ST_PDOWN && $past(mode) == ST_PDOWN) |-> (ale_force && !ale_force_val && !code_fetch_strobe_val))
        else $error("strobes not low in power-down"); // [RULE16]
    idle_strobes_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == ST_IDLE && $past(mode) == ST_IDLE) |-> (ale_force_val && code_fetch_strobe_val))
        else $error("strobes not high in idle"); // [RULE15]
    idle_irq_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == ST_IDLE && irq_pending && !rst_active) |=> (mode == ST_RUN && !pwr_ctrl[BIT_IDLE]))
        else $error("idle not left on interrupt"); // [RULE9]
    both_req_pd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == ST_RUN && pwr_ctrl[BIT_PDOWN] && !rst_active) |=> mode == ST_PDOWN)
        else $error("power-down not entered"); // [RULE17]
    osc_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == ST_PDOWN |=> !osc_run || rst_active) else $error("oscillator still running"); // [RULE11]
    ea_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!rst_active && !$past(rst_active)) |-> $stable(ea_lat)) else $error("code select changed"); // [RULE3]
    table_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        code_read_grant |-> $past(code_read_req && code_read_is_table)) else $error("non-table code read"); // [RULE6]
    div_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        div2 |=> !div2) else $error("divider stuck"); // [RULE4]
    idle_core_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == ST_IDLE && $past(mode) == ST_IDLE) |-> !core_clk_en) else $error("core clocked in idle"); // [RULE7]
endmodule // pwr_ctl

// file: dv/reset_source.sv
// Purpose: Model of the external reset circuit driving the reset pin.
// Assumes: The pin has a pull-down inside the device, so a released pin reads 0.
// Notes: Holds the pin high at power-on long enough to cover oscillator start-up.
`timescale 1ns/1ps
module reset_source
#(
    parameter int POR_CYC = 60
)
(
    // Clock
    input wire logic aclk,
    // Command
    input wire logic fire,
    input wire logic [7:0] hold,
    // Pin
    output logic reset_pin
);
    int cnt = POR_CYC;
    // A command restarts the high time; the caller picks short or long holds.
    always @(posedge aclk)
    begin
        if (fire)
            cnt <= int'(hold);
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign reset_pin = (cnt != 0);
endmodule // reset_source

// file: dv/reset_and_low_power_control_tb.sv
// Purpose: Self-checking bench for the reset and low-power controller.
// Assumes: SECURE is set so the protection path is exercised.
// Notes: Registers are reached over AXI4-Lite with bounded waits.
`timescale 1ns/1ps
module reset_and_low_power_control_tb;
    import pwr_ctl_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'h1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic ecs = 1, irq = 0, req = 0, tbl = 0, intl = 0, xf = 0, tm = 0;
    logic core_reset, core_clk_en, periph_clk_en, osc_run, ram_only_retain, ext_code_select;
    logic code_read_grant, ale_force, ale_force_val, cfs_force, cfs_val, port0_float, port2_addr;
    logic reset_pin, fire = 0;
    logic [7:0] hold = 0;
    int errors = 0, n_checks = 0;
    pwr_ctl #(.SECURE(1'b1)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .reset_pin(reset_pin), .ext_code_sel_pin(ecs), .irq_pending(irq), .code_read_req(req),
        .code_read_is_table(tbl), .code_read_internal(intl), .fetch_from_external(xf),
        .test_mode_read(tm), .core_reset(core_reset), .core_clk_en(core_clk_en),
        .periph_clk_en(periph_clk_en), .osc_run(osc_run), .ram_only_retain(ram_only_retain),
        .ext_code_select(ext_code_select), .code_read_grant(code_read_grant), .ale_force(ale_force),
        .ale_force_val(ale_force_val), .code_fetch_strobe_force(cfs_force),
        .code_fetch_strobe_val(cfs_val), .port0_float(port0_float), .port2_addr(port2_addr));
    reset_source #(.POR_CYC(60)) rst_src (.aclk(aclk), .fire(fire), .hold(hold), .reset_pin(reset_pin));
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    // ==========================================================
    // Helpers
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n > 300)
        begin
            $display("[FAIL] t=%0t wait ran out", $time);
            errors++;
            wrap_up();
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
            errors++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit a_ok, w_ok;
        n = 0;
        a_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (bvalid !== 1 || !(a_ok && w_ok))
        begin
            @(posedge aclk);
            if (!a_ok && awready === 1)
            begin
                a_ok = 1;
                awvalid <= 0;
            end
            if (!w_ok && wready === 1)
            begin
                w_ok = 1;
                wvalid <= 0;
            end
            tmo(++n);
        end
        bready <= 0;
        chk(bresp, er, "bresp");
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (rvalid !== 1)
        begin
            @(posedge aclk);
            if (arvalid === 1 && arready === 1)
                arvalid <= 0;
            tmo(++n);
        end
        rready <= 0;
        chk(rresp, er, "rresp");
        chk(rdata, ed, "rdata");
    endtask
    task automatic pin_reset(input logic [7:0] h, input logic sel);
        int n;
        n = 0;
        @(posedge aclk);
        ecs <= sel;
        hold <= h;
        fire <= 1;
        @(posedge aclk);
        fire <= 0;
        while (core_reset !== 1)
        begin
            @(posedge aclk);
            tmo(++n);
        end
        while (core_reset !== 0)
        begin
            @(posedge aclk);
            tmo(++n);
        end
        ecs <= ~sel;
    endtask
    task automatic en_count(output int c, output int p);
        c = 0;
        p = 0;
        repeat (24)
        begin
            @(posedge aclk);
            c += (core_clk_en === 1);
            p += (periph_clk_en === 1);
        end
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin : main
        int c, p, n;
        logic [5:0] cr [6];
        cr = '{6'b11_0001, 6'b10_1000, 6'b11_1100, 6'b11_1010, 6'b11_1001, 6'b11_0101};
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        n = 0;
        while (core_reset !== 0 || reset_pin !== 0)
        begin
            @(posedge aclk);
            tmo(++n);
        end
        ecs <= 0;
        rd(OFF_PWR_CTRL, {24'h0, PWR_CTRL_RST}, RESP_OKAY);
        rd(OFF_STATUS, {28'h0, 1'b1, ST_RUN}, RESP_OKAY);
        chk(ext_code_select, 1'b1, "select kept");
        rd(12'h00c, 32'h0000_0000, RESP_SLVERR);
        wr(12'h00c, 32'h0000_0003, RESP_SLVERR);
        en_count(c, p);
        chk(c, 12, "core enables run");
        $display("test power_on done");
        hold <= 8'd10;
        fire <= 1;
        @(posedge aclk);
        fire <= 0;
        repeat (60)
        begin
            @(posedge aclk);
            chk(core_reset, 1'b0, "short pulse");
        end
        $display("test short_pulse done");
        wr(OFF_PWR_CTRL, 32'h0000_0001, RESP_OKAY);
        rd(OFF_STATUS, {28'h0, 1'b1, ST_IDLE}, RESP_OKAY);
        en_count(c, p);
        chk(c, 0, "core halted");
        chk(p, 12, "periph run");
        chk({ale_force, ale_force_val, cfs_force, cfs_val}, 4'b1111, "idle strobes");
        chk({port0_float, port2_addr, osc_run}, 3'b111, "idle ports");
        irq <= 1;
        repeat (4) @(posedge aclk);
        irq <= 0;
        rd(OFF_STATUS, {28'h0, 1'b1, ST_RUN}, RESP_OKAY);
        rd(OFF_PWR_CTRL, 32'h0000_0000, RESP_OKAY);
        rd(OFF_WAKE, 32'h0000_0001, RESP_OKAY);
        wr(OFF_WAKE, 32'h0000_0001, RESP_OKAY);
        rd(OFF_WAKE, 32'h0000_0000, RESP_OKAY);
        $display("test idle_irq done");
        wr(OFF_PWR_CTRL, 32'h0000_0001, RESP_OKAY);
        pin_reset(8'd60, 1'b0);
        rd(OFF_STATUS, {28'h0, 1'b0, ST_RUN}, RESP_OKAY);
        rd(OFF_PWR_CTRL, 32'h0000_0000, RESP_OKAY);
        $display("test idle_reset done");
        wr(OFF_PWR_CTRL, 32'h0000_0003, RESP_OKAY);
        rd(OFF_STATUS, {28'h0, 1'b0, ST_PDOWN}, RESP_OKAY);
        chk({osc_run, ram_only_retain}, 2'b01, "oscillator off");
        chk({ale_force, ale_force_val, cfs_force, cfs_val}, 4'b1010, "pdown strobes");
        chk({port0_float, port2_addr}, 2'b00, "pdown ports");
        irq <= 1;
        repeat (6) @(posedge aclk);
        rd(OFF_STATUS, {28'h0, 1'b0, ST_PDOWN}, RESP_OKAY);
        irq <= 0;
        pin_reset(8'd60, 1'b1);
        rd(OFF_STATUS, {28'h0, 1'b1, ST_RUN}, RESP_OKAY);
        chk(osc_run, 1'b1, "oscillator on");
        $display("test power_down done");
        for (int i = 0; i < 6; i++)
        begin
            {req, tbl, intl, xf, tm} <= cr[i][5:1];
            repeat (3) @(posedge aclk);
            chk(code_read_grant, cr[i][0], "grant");
        end
        req <= 0;
        $display("test code_protect done");
        wrap_up();
    end
endmodule // reset_and_low_power_control_tb
